// ### core/ssp_device.sv
`timescale 1ns/1ps
`default_nettype none
// Synthesizer end of the programming port
module ssp_device #(
	parameter bit POWER_ACTIVE_HIGH = 1'b1
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	ssp_if.dev link,
	input wire logic prin_hw_on_i,
	input wire logic aux_hw_on_i,
	output logic [16:0] prin_main_ratio_o,
	output logic [16:0] prin_ref_ratio_o,
	output logic [16:0] aux_main_ratio_o,
	output logic [16:0] aux_ref_ratio_o,
	output logic [16:0] control_o,
	output logic [1:0] lock_src_o,
	output logic [1:0] pump_ratio_o,
	output logic prin_enable_o,
	output logic aux_enable_o,
	output logic [6:0] dac_code_o,
	output logic test_mode_o,
	output logic update_o,
	output logic [3:0] update_addr_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	// Lane order: strobe, clock, data, principal pin, auxiliary pin
	localparam int PIN_COUNT = 5;
	// Idle levels: strobe high, clock and data low, power pins on
	localparam logic [PIN_COUNT-1:0] PIN_RESET = 5'h13;

	logic [PIN_COUNT-1:0] pin_raw;
	logic [PIN_COUNT-1:0] pin_sync;
	logic strobe_n_s;
	logic sclk_s;
	logic sdata_s;
	logic prin_hw_on_s;
	logic aux_hw_on_s;

	// All three lines are inputs only
	assign pin_raw = {link.strobe_n, link.sclk, link.sdata, prin_hw_on_i, aux_hw_on_i};

	ssp_sync #(
		.WIDTH(PIN_COUNT),
		.RESET_VAL(PIN_RESET)
	) u_sync (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.d_i(pin_raw),
		.q_o(pin_sync)
	);

	assign strobe_n_s = pin_sync[4];
	assign sclk_s = pin_sync[3];
	assign sdata_s = pin_sync[2];
	assign prin_hw_on_s = pin_sync[1];
	assign aux_hw_on_s = pin_sync[0];

	////////////////////////////////////////////////////////////////////////////////
	// Edge detection

	logic sclk_prev_reg;
	logic strobe_prev_reg;
	logic shift_evt;
	logic release_evt;

	// Previous synchronised levels
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			sclk_prev_reg <= 1'b0;
			strobe_prev_reg <= 1'b1;
		end else begin
			sclk_prev_reg <= sclk_s;
			strobe_prev_reg <= strobe_n_s;
		end
	end

	// Clock rise counts only while strobe is low
	assign shift_evt = sclk_s && !sclk_prev_reg && !strobe_n_s;
	// Strobe low-to-high is the load moment
	assign release_evt = strobe_n_s && !strobe_prev_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Shift register

	logic [ssp_pkg::FRAME_BITS-1:0] shift_reg;
	logic [ssp_pkg::FRAME_BITS-1:0] shift_next;
	logic [ssp_pkg::DATA_BITS-1:0] frame_data;
	logic [ssp_pkg::ADDR_BITS-1:0] frame_addr;

	// Oldest bit falls off the top, no bit count kept
	assign shift_next = {shift_reg[ssp_pkg::FRAME_BITS-2:0], sdata_s};

	// Shifting is independent of power state
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			shift_reg <= '0;
		end else if (shift_evt) begin
			shift_reg <= shift_next;
		end
	end

	// Data leads, address trails
	assign frame_addr = shift_reg[ssp_pkg::ADDR_BITS-1:0];
	assign frame_data = shift_reg[ssp_pkg::FRAME_BITS-1:ssp_pkg::ADDR_BITS];

	////////////////////////////////////////////////////////////////////////////////
	// Address decode

	function automatic logic ssp_addr_known(input logic [3:0] addr);
		unique case (addr)
			ssp_pkg::ADDR_TEST,
			ssp_pkg::ADDR_CONTROL,
			ssp_pkg::ADDR_PRIN_MAIN,
			ssp_pkg::ADDR_PRIN_REF,
			ssp_pkg::ADDR_AUX_MAIN,
			ssp_pkg::ADDR_AUX_REF,
			ssp_pkg::ADDR_CONVERTER: ssp_addr_known = 1'b1;
			default: ssp_addr_known = 1'b0;
		endcase
	endfunction

	logic load_ok;

	// Unknown addresses are dropped
	assign load_ok = release_evt && ssp_addr_known(frame_addr);

	////////////////////////////////////////////////////////////////////////////////
	// Latches

	logic [16:0] test_latch_reg;
	logic [16:0] control_latch_reg;
	logic [16:0] principal_main_ratio_reg;
	logic [16:0] principal_ref_ratio_reg;
	logic [16:0] auxiliary_main_ratio_reg;
	logic [16:0] auxiliary_ref_ratio_reg;
	logic [16:0] converter_code_reg;

	// Presets on reset, no clear on power-down
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			test_latch_reg <= ssp_pkg::RST_TEST;
			control_latch_reg <= ssp_pkg::RST_CONTROL;
			principal_main_ratio_reg <= ssp_pkg::RST_PRIN_MAIN;
			principal_ref_ratio_reg <= ssp_pkg::RST_PRIN_REF;
			auxiliary_main_ratio_reg <= ssp_pkg::RST_AUX_MAIN;
			auxiliary_ref_ratio_reg <= ssp_pkg::RST_AUX_REF;
			converter_code_reg <= ssp_pkg::RST_CONVERTER;
		end else if (load_ok) begin
			// Plain binary storage of the data field
			unique case (frame_addr)
				ssp_pkg::ADDR_TEST: test_latch_reg <= frame_data;
				ssp_pkg::ADDR_CONTROL: control_latch_reg <= frame_data;
				ssp_pkg::ADDR_PRIN_MAIN: principal_main_ratio_reg <= frame_data;
				ssp_pkg::ADDR_PRIN_REF: principal_ref_ratio_reg <= frame_data;
				ssp_pkg::ADDR_AUX_MAIN: auxiliary_main_ratio_reg <= frame_data;
				ssp_pkg::ADDR_AUX_REF: auxiliary_ref_ratio_reg <= frame_data;
				ssp_pkg::ADDR_CONVERTER: converter_code_reg <= frame_data;
				default: test_latch_reg <= test_latch_reg;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Apply stage

	logic apply_reg;
	logic [3:0] apply_addr_reg;

	// One cycle after the latch, the new value goes out
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			apply_reg <= 1'b0;
			apply_addr_reg <= 4'h0;
		end else begin
			apply_reg <= load_ok;
			apply_addr_reg <= load_ok ? frame_addr : apply_addr_reg;
		end
	end

	// Divider ratios and converter code to the datapath
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			prin_main_ratio_o <= ssp_pkg::RST_PRIN_MAIN;
			prin_ref_ratio_o <= ssp_pkg::RST_PRIN_REF;
			aux_main_ratio_o <= ssp_pkg::RST_AUX_MAIN;
			aux_ref_ratio_o <= ssp_pkg::RST_AUX_REF;
			dac_code_o <= ssp_pkg::RST_CONVERTER[6:0];
			test_mode_o <= 1'b0;
		end else begin
			prin_main_ratio_o <= principal_main_ratio_reg;
			prin_ref_ratio_o <= principal_ref_ratio_reg;
			aux_main_ratio_o <= auxiliary_main_ratio_reg;
			aux_ref_ratio_o <= auxiliary_ref_ratio_reg;
			dac_code_o <= converter_code_reg[ssp_pkg::CODE_BITS-1:0];
			test_mode_o <= |test_latch_reg;
		end
	end

	// Control fields to the analogue side
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			control_o <= ssp_pkg::RST_CONTROL;
			lock_src_o <= 2'h0;
			pump_ratio_o <= 2'h3;
		end else begin
			control_o <= control_latch_reg;
			lock_src_o <= {control_latch_reg[ssp_pkg::CTL_LOCK_SEL_PRINCIPAL],
				control_latch_reg[ssp_pkg::CTL_LOCK_SEL_AUXILIARY]};
			pump_ratio_o <= {control_latch_reg[ssp_pkg::CTL_PUMP_RATIO_HI],
				control_latch_reg[ssp_pkg::CTL_PUMP_RATIO_LO]};
		end
	end

	// Software bit in variant polarity, gated by the hardware pin
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			prin_enable_o <= 1'b0;
			aux_enable_o <= 1'b0;
		end else begin
			prin_enable_o <= prin_hw_on_s &&
				(control_latch_reg[ssp_pkg::CTL_PRIN_POWER] == POWER_ACTIVE_HIGH);
			aux_enable_o <= aux_hw_on_s &&
				(control_latch_reg[ssp_pkg::CTL_AUX_POWER] == POWER_ACTIVE_HIGH);
		end
	end

	// Update notice for the consuming logic
	assign update_o = apply_reg;
	assign update_addr_o = apply_addr_reg;

endmodule
`default_nettype wire

// ### core/ssp_pkg.sv
// Operation
// - Three host-driven lines, no readback path
// - Clock edges ignored while strobe high
// - Strobe rise latches data into addressed latch
// - Only last 21 shifted bits retained
// - No bit counting, any length accepted
// - Port works during any power-down
// - Latches kept through power-down
// - Host sends MSB first, address last
// - Last four bits address, 17 data
// - Decode on strobe rise, not clock
// - Addresses 0,1,4-8 select the latches
// - Test writes carry zeros; zeros restore
// - Host holds strobe low at power-up
// - Divider ratios preset 4500/65/8000/1040
// - Control presets ones except lock select
// - Host keeps strobe high at least 4 us
// - Shorter gap only with fast inputs
// - One power bit per synthesizer, variant polarity
// - Two bits select lock indicator source
// - Two bits select principal pump ratio
// - Converter latch holds 7-bit code
package ssp_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Frame layout
	localparam int FRAME_BITS = 21;
	localparam int DATA_BITS = 17;
	localparam int ADDR_BITS = 4;
	localparam int CODE_BITS = 7;

	////////////////////////////////////////////////////////////////////////////////
	// Latch addresses
	localparam logic [3:0] ADDR_TEST = 4'h0;
	localparam logic [3:0] ADDR_CONTROL = 4'h1;
	localparam logic [3:0] ADDR_PRIN_MAIN = 4'h4;
	localparam logic [3:0] ADDR_PRIN_REF = 4'h5;
	localparam logic [3:0] ADDR_AUX_MAIN = 4'h6;
	localparam logic [3:0] ADDR_AUX_REF = 4'h7;
	localparam logic [3:0] ADDR_CONVERTER = 4'h8;

	////////////////////////////////////////////////////////////////////////////////
	// Control field positions
	localparam int CTL_LOCK_SEL_PRINCIPAL = 12;
	localparam int CTL_LOCK_SEL_AUXILIARY = 11;
	localparam int CTL_PUMP_RATIO_HI = 10;
	localparam int CTL_PUMP_RATIO_LO = 9;
	localparam int CTL_AUX_POWER = 8;
	localparam int CTL_PRIN_POWER = 7;

	////////////////////////////////////////////////////////////////////////////////
	// Power-on presets
	localparam logic [16:0] RST_TEST = 17'h00000;
	localparam logic [16:0] RST_CONTROL = 17'h1E7FF;
	localparam logic [16:0] RST_PRIN_MAIN = 17'h01194;
	localparam logic [16:0] RST_PRIN_REF = 17'h00041;
	localparam logic [16:0] RST_AUX_MAIN = 17'h01F40;
	localparam logic [16:0] RST_AUX_REF = 17'h00410;
	localparam logic [16:0] RST_CONVERTER = 17'h00000;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int STROBE_GAP_NS = 4000;
	localparam int STROBE_GAP_CYC = (STROBE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCLK_HALF_CYC = 10;
	localparam int SYNC_STAGES = 2;

endpackage

// ### core/ssp_if.sv
`timescale 1ns/1ps
`default_nettype none
// Three host-driven programming lines
interface ssp_if;
	logic sdata;
	logic sclk;
	logic strobe_n;

	modport host (output sdata, output sclk, output strobe_n);
	modport dev (input sdata, input sclk, input strobe_n);
endinterface
`default_nettype wire

// ### core/ssp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser, one lane per bit
module ssp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	// A lane count below one leaves nothing to synchronise
	if (WIDTH < 1) begin : g_chk
		$error("ssp_sync width out of range");
	end

	logic [WIDTH-1:0] meta_reg;

	// First stage read only by the second
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			meta_reg <= RESET_VAL;
			q_o <= RESET_VAL;
		end else begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end

endmodule
`default_nettype wire

// ### core/ssp_host.sv
`timescale 1ns/1ps
`default_nettype none
// Controller end: shifts one frame per request
module ssp_host #(
	parameter int HALF_CYC = ssp_pkg::SCLK_HALF_CYC,
	parameter int GAP_CYC = ssp_pkg::STROBE_GAP_CYC
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	ssp_if.host link,
	input wire logic req_valid_i,
	input wire logic [3:0] req_addr_i,
	input wire logic [16:0] req_data_i,
	output logic req_ready_o
);

	// Device samples through two flops, so a half period must outlast them
	if (HALF_CYC < 4 || HALF_CYC > 255 || GAP_CYC < 1 || GAP_CYC + HALF_CYC > 65536) begin : g_chk
		$error("ssp_host timing parameters out of range");
	end

	typedef enum logic [3:0] {
		HS_IDLE = 4'b0001,
		HS_LOW = 4'b0010,
		HS_HIGH = 4'b0100,
		HS_GAP = 4'b1000
	} ssp_hstate_type;

	ssp_hstate_type state_reg;
	logic [20:0] frame_reg;
	logic [4:0] bits_reg;
	logic [15:0] cnt_reg;
	logic sclk_reg;
	logic strobe_n_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			state_reg <= HS_IDLE;
			cnt_reg <= 16'h0000;
			bits_reg <= 5'h00;
		end else begin
			unique case (state_reg)
				HS_IDLE: begin
					if (req_valid_i) begin
						state_reg <= HS_LOW;
						cnt_reg <= 16'h0000;
						bits_reg <= 5'h00;
					end
				end
				HS_LOW: begin
					if (cnt_reg == 16'(HALF_CYC - 1)) begin
						state_reg <= HS_HIGH;
						cnt_reg <= 16'h0000;
					end else begin
						cnt_reg <= cnt_reg + 16'h0001;
					end
				end
				HS_HIGH: begin
					if (cnt_reg == 16'(HALF_CYC - 1)) begin
						cnt_reg <= 16'h0000;
						bits_reg <= bits_reg + 5'h01;
						state_reg <= (bits_reg == 5'(ssp_pkg::FRAME_BITS - 1)) ? HS_GAP : HS_LOW;
					end else begin
						cnt_reg <= cnt_reg + 16'h0001;
					end
				end
				HS_GAP: begin
					// Strobe high for the minimum spacing
					if (cnt_reg == 16'(GAP_CYC + HALF_CYC - 1)) begin
						state_reg <= HS_IDLE;
					end else begin
						cnt_reg <= cnt_reg + 16'h0001;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Line drivers

	// Frame loaded data first, shifted out top bit first
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			frame_reg <= '0;
		end else if (state_reg == HS_IDLE && req_valid_i) begin
			frame_reg <= {req_data_i, req_addr_i};
		end else if (state_reg == HS_HIGH && cnt_reg == 16'(HALF_CYC - 1)) begin
			frame_reg <= {frame_reg[19:0], 1'b0};
		end
	end

	// Strobe low from power-up until the first frame ends
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			strobe_n_reg <= 1'b0;
		end else if (state_reg == HS_IDLE && req_valid_i) begin
			strobe_n_reg <= 1'b0;
		end else if (state_reg == HS_GAP && cnt_reg == 16'(HALF_CYC - 1)) begin
			strobe_n_reg <= 1'b1;
		end
	end

	// Serial clock high during the second half of each bit
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			sclk_reg <= 1'b0;
		end else begin
			sclk_reg <= (state_reg == HS_LOW && cnt_reg == 16'(HALF_CYC - 1)) ||
				(state_reg == HS_HIGH && cnt_reg != 16'(HALF_CYC - 1));
		end
	end

	// Ready only when idle
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			req_ready_o <= 1'b0;
		end else begin
			req_ready_o <= (state_reg == HS_IDLE) && !req_valid_i;
		end
	end

	// Host drives all three lines
	assign link.sdata = frame_reg[20];
	assign link.sclk = sclk_reg;
	assign link.strobe_n = strobe_n_reg;

endmodule
`default_nettype wire

// ### bench/ssp_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Wire-level checks on the host side of the programming link
module ssp_link_monitor #(
	parameter int GAP_CYC = ssp_pkg::STROBE_GAP_CYC
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic sdata,
	input wire logic sclk,
	input wire logic strobe_n
);
	logic sclk_reg;
	logic [4:0] bit_cnt_reg;
	logic [15:0] hi_cnt_reg;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	////////////////////////////////////////////////////////////////////////////////
	// Serial clock history
	always_ff @(posedge clk_i) begin
		sclk_reg <= nrst_i ? sclk : 1'b0;
	end

	// Rising serial edges within one frame
	always_ff @(posedge clk_i) begin
		if (!nrst_i || strobe_n) begin
			bit_cnt_reg <= 5'h00;
		end else if (sclk && !sclk_reg && bit_cnt_reg != 5'h1F) begin
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
		end
	end

	// Cycles spent with the strobe high
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !strobe_n) begin
			hi_cnt_reg <= 16'h0000;
		end else if (hi_cnt_reg != 16'hFFFF) begin
			hi_cnt_reg <= hi_cnt_reg + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Properties
	sequence s_sclk_pulse;
		sclk [*8] ##3 !sclk;
	endsequence
	property p_power_up_low;
		$rose(nrst_i) |-> !strobe_n;
	endproperty
	property p_gap;
		$fell(strobe_n) |-> hi_cnt_reg >= GAP_CYC;
	endproperty
	property p_bits;
		$rose(strobe_n) |-> bit_cnt_reg == 5'h15;
	endproperty
	property p_idle_clk;
		strobe_n |-> !sclk;
	endproperty
	property p_sclk_high;
		$rose(sclk) |-> s_sclk_pulse;
	endproperty
	property p_data_stable;
		$rose(sclk) |-> $stable(sdata);
	endproperty
	property p_first_edge;
		$fell(strobe_n) |-> ##[1:20] $rose(sclk);
	endproperty
	property p_strobe_hold;
		sclk |-> !strobe_n && $stable(strobe_n);
	endproperty

	a_power_up_low: assert property (p_power_up_low)
		else $error("strobe not low after reset");
	a_gap: assert property (p_gap)
		else $error("strobe high gap too short");
	a_bits: assert property (p_bits)
		else $error("frame bit count wrong");
	a_idle_clk: assert property (p_idle_clk)
		else $error("serial clock high outside frame");
	a_sclk_high: assert property (p_sclk_high)
		else $error("serial clock high phase wrong");
	a_data_stable: assert property (p_data_stable)
		else $error("data moved at clock rise");
	a_first_edge: assert property (p_first_edge)
		else $error("no clock after strobe fall");
	a_strobe_hold: assert property (p_strobe_hold)
		else $error("strobe moved while clock high");
endmodule
`default_nettype wire

// ### bench/synth_serial_program_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Host and device joined; a second device, other power polarity, takes hand-made frames
module synth_serial_program_port_tb;
	logic clk, nrst, req_valid, req_ready, prin_hw, aux_hw, pen, aen, tm, upd, b_tm, b_upd;
	logic b_pen, b_aen;
	logic [3:0] req_addr, upd_a, b_upd_a;
	logic [16:0] req_data, pm, pr, am, ar, ctl, b_pm, b_pr, c;
	logic [1:0] lock, pump, kk;
	logic [6:0] dac;
	logic [20:0] wire_sh;
	logic [16:0] rv [5] = '{17'h1FFFF, 17'h00008, 17'h03FFF, 17'h007FF, 17'h1FF7F};
	logic [3:0] ua [4] = '{4'h2, 4'h3, 4'h9, 4'hF};
	int wire_n, n_upd, b_n_upd, fails, compares, i;

	ssp_if link();
	ssp_if f_link();
	ssp_host #(.HALF_CYC(ssp_pkg::SCLK_HALF_CYC), .GAP_CYC(ssp_pkg::STROBE_GAP_CYC)) i_ssp_host (
		.clk_i(clk), .nrst_i(nrst), .link(link),
		.req_valid_i(req_valid), .req_addr_i(req_addr), .req_data_i(req_data),
		.req_ready_o(req_ready));
	ssp_device i_ssp_device (.clk_i(clk), .nrst_i(nrst), .link(link), .prin_hw_on_i(prin_hw),
		.aux_hw_on_i(aux_hw), .prin_main_ratio_o(pm), .prin_ref_ratio_o(pr),
		.aux_main_ratio_o(am), .aux_ref_ratio_o(ar), .control_o(ctl), .lock_src_o(lock),
		.pump_ratio_o(pump), .prin_enable_o(pen), .aux_enable_o(aen), .dac_code_o(dac),
		.test_mode_o(tm), .update_o(upd), .update_addr_o(upd_a));
	ssp_device #(.POWER_ACTIVE_HIGH(1'b0)) i_ssp_device_b (.clk_i(clk), .nrst_i(nrst),
		.link(f_link), .prin_hw_on_i(prin_hw),
		.aux_hw_on_i(aux_hw), .prin_main_ratio_o(b_pm), .prin_ref_ratio_o(b_pr),
		.aux_main_ratio_o(), .aux_ref_ratio_o(), .control_o(), .lock_src_o(), .pump_ratio_o(),
		.prin_enable_o(b_pen), .aux_enable_o(b_aen), .dac_code_o(), .test_mode_o(b_tm),
		.update_o(b_upd), .update_addr_o(b_upd_a));
	ssp_link_monitor #(.GAP_CYC(ssp_pkg::STROBE_GAP_CYC)) i_ssp_link_monitor (.clk_i(clk),
		.nrst_i(nrst),
		.sdata(link.sdata), .sclk(link.sclk), .strobe_n(link.strobe_n));

	////////////////////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Bits seen on the wire and load pulses
	always @(posedge link.sclk) begin
		if (link.strobe_n === 1'b0) begin
			wire_sh <= {wire_sh[19:0], link.sdata};
			wire_n <= wire_n + 1;
		end
	end
	always @(negedge link.strobe_n) wire_n <= 0;
	always @(posedge clk) begin
		if (upd === 1'b1) n_upd <= n_upd + 1;
		if (b_upd === 1'b1) b_n_upd <= b_n_upd + 1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("Counts: compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic wait_ready;
		int k;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (req_ready !== 1'b1 && k < 2000);
		if (k >= 2000) begin
			fails++;
			end_sim;
		end
	endtask

	// One frame through the host, then wire and load checks
	task automatic send(input logic [3:0] a, input logic [16:0] d, input int exp_upd);
		int u;
		wait_ready;
		u = n_upd;
		@(posedge clk);
		req_valid <= 1'b1;
		req_addr <= a;
		req_data <= d;
		@(posedge clk);
		req_valid <= 1'b0;
		wait_ready;
		chk(wire_sh, {d, a});
		chk(wire_n, 21);
		chk(n_upd - u, exp_upd);
		if (exp_upd == 1) chk(upd_a, a);
	endtask

	// Hand-made frame of n bits on the second link; lo=0 keeps strobe high
	task automatic fsend(input logic [31:0] bits, input int n, input logic lo);
		int u;
		u = b_n_upd;
		@(posedge clk);
		f_link.strobe_n <= ~lo;
		repeat (10) @(posedge clk);
		for (int j = n - 1; j >= 0; j--) begin
			f_link.sdata <= bits[j];
			repeat (10) @(posedge clk);
			f_link.sclk <= 1'b1;
			repeat (10) @(posedge clk);
			f_link.sclk <= 1'b0;
		end
		f_link.sdata <= ~f_link.sdata;
		repeat (10) @(posedge clk);
		chk(b_n_upd - u, 0);
		f_link.strobe_n <= 1'b1;
		repeat (500) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		nrst = 1'b0;
		req_valid = 1'b0;
		req_addr = 4'h0;
		req_data = 17'h00000;
		prin_hw = 1'b1;
		aux_hw = 1'b1;
		f_link.sdata = 1'b0;
		f_link.sclk = 1'b0;
		f_link.strobe_n = 1'b1;
		wire_n = 0;
		n_upd = 0;
		b_n_upd = 0;
		fails = 0;
		compares = 0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk(link.strobe_n, 1'b0);
		chk(pm, 17'h01194);
		chk(pr, 17'h00041);
		chk(am, 17'h01F40);
		chk(ar, 17'h00410);
		c = 17'h1FFFF & ~(17'h00001 << ssp_pkg::CTL_LOCK_SEL_PRINCIPAL);
		c = c & ~(17'h00001 << ssp_pkg::CTL_LOCK_SEL_AUXILIARY);
		chk(ctl, c);
		chk({lock, pump, dac, tm}, {2'h0, 2'h3, 7'h00, 1'b0});
		chk({pen, aen}, 2'h3);
		chk({b_pen, b_aen}, 2'h0);
		$display("test presets done");
		for (i = 0; i < 5; i++) send(4'h4 + i[3:0], rv[i], 1);
		chk(pm, rv[0]);
		chk(pr, rv[1]);
		chk(am, rv[2]);
		chk(ar, rv[3]);
		chk(dac, rv[4][6:0]);
		$display("test ratios done");
		for (i = 0; i < 4; i++) begin
			kk = i[1:0];
			c[ssp_pkg::CTL_LOCK_SEL_PRINCIPAL] = kk[1];
			c[ssp_pkg::CTL_LOCK_SEL_AUXILIARY] = kk[0];
			c[ssp_pkg::CTL_PUMP_RATIO_HI] = ~kk[1];
			c[ssp_pkg::CTL_PUMP_RATIO_LO] = ~kk[0];
			c[ssp_pkg::CTL_AUX_POWER] = kk[0];
			c[ssp_pkg::CTL_PRIN_POWER] = kk[1];
			send(4'h1, c, 1);
			chk(ctl, c);
			chk(lock, kk);
			chk(pump, 2'(~kk));
			chk({pen, aen}, kk);
		end
		$display("test control done");
		for (i = 0; i < 4; i++) send(ua[i], 17'h00000, 0);
		chk(pm, rv[0]);
		chk(ctl, c);
		$display("test unknown addresses done");
		@(posedge clk);
		prin_hw <= 1'b0;
		aux_hw <= 1'b0;
		send(4'h4, 17'h00200, 1);
		chk({pm, pen, aen}, {17'h00200, 2'h0});
		@(posedge clk);
		prin_hw <= 1'b1;
		aux_hw <= 1'b1;
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk({pm, pen, aen}, {17'h00200, 2'h3});
		send(4'h0, 17'h00000, 1);
		chk(tm, 1'b0);
		$display("test power-down done");
		fsend({4'hF, 17'h0ABCD, 4'h5}, 25, 1'b1);
		chk({b_pr, b_upd_a}, {17'h0ABCD, 4'h5});
		fsend(32'h00000004, 4, 1'b1);
		chk(b_pm, 17'h0BCD5);
		i = b_n_upd;
		fsend(32'hFFFFFFFF, 21, 1'b0);
		fsend(32'h00000000, 0, 1'b1);
		chk(b_n_upd - i, 1);
		chk(b_upd_a, 4'h4);
		fsend({17'h00001, 4'h0}, 21, 1'b1);
		chk(b_tm, 1'b1);
		fsend(32'h00000000, 21, 1'b1);
		chk(b_tm, 1'b0);
		// Cleared power bits switch the other variant on
		fsend({17'h00000, 4'h1}, 21, 1'b1);
		chk({b_pen, b_aen}, 2'h3);
		$display("test faulty frames done");
		end_sim;
	end
endmodule
`default_nettype wire
